// ==== system_extension_regs_map.vh ====
// index map, field positions, reset values and key for the system extension register bank
// Operation
// - extension registers are unreachable unless the lock register holds the unlock key
// - reset leaves the bank locked; it stays open until the key changes
// - screen width from bits 7-6 with bit 0 on top; pixel length bits 5-4
// - logical screen width bits 9-8 come from second register bits 5-4
// - old display start 19-18 from bits 1-0, host base 19-18 from 3-2
// - linear addressing byte swap mode from memory control a bits 2-1
// - mapped io scheme chosen by memory control a bits 4-3
// - bit 5 places mapped io window at a8000 or b8000; bit 6 nibble swap
// - memory control b bits 1-0 swap mode for other accesses
// - display fifo m parameter built from bit 2 and bits 7-3
// - general input port readable only while palette control bit 2 is set
// - palette control bit 4 selects x-11 style hardware cursor
// - palette control bit 7 floats the video clock output pin
// - sync control bit 1 floats the horizontal sync output
// - sync control bit 2 floats the vertical sync output
// - window size bits 1-0, linear enable bit 4, row strobe timing bit 7
// - bit 3 of linear window control sets address latch timing
// - 16-bit window base gives host address bits 31-16
// - general output port drives its 8-bit register content
// - horizontal overflow bits extend total, ends, starts and fifo fetch
// - vertical overflow bits 0,1,2,4,6 give bit 10 of vertical values
`ifndef SYSTEM_EXTENSION_REGS_MAP_VH
`define SYSTEM_EXTENSION_REGS_MAP_VH

// register indices in the crt index space
`define IDX_LOCK_KEY_TWO       8'h39
`define IDX_EXT_SYSTEM_CTRL_A  8'h50
`define IDX_EXT_SYSTEM_CTRL_B  8'h51
`define IDX_FIRMWARE_FLAG_A    8'h52
`define IDX_MEMORY_CTRL_A      8'h53
`define IDX_MEMORY_CTRL_B      8'h54
`define IDX_PALETTE_EXT_CTRL   8'h55
`define IDX_EXTERNAL_SYNC_CTRL 8'h56
`define IDX_LINEAR_WINDOW_CTRL 8'h58
`define IDX_LINEAR_BASE_HI     8'h59
`define IDX_LINEAR_BASE_LO     8'h5a
`define IDX_GENERAL_OUTPUT     8'h5c
`define IDX_HORIZ_OVERFLOW     8'h5d
`define IDX_VERT_OVERFLOW      8'h5e

// writable bit masks; zero bits are reserved
`define MASK_EXT_SYSTEM_CTRL_A  8'hf1
`define MASK_EXT_SYSTEM_CTRL_B  8'h3f
`define MASK_FIRMWARE_FLAG_A    8'hff
`define MASK_MEMORY_CTRL_A      8'h7e
`define MASK_MEMORY_CTRL_B      8'hff
`define MASK_PALETTE_EXT_CTRL   8'h94
`define MASK_EXTERNAL_SYNC_CTRL 8'h06
`define MASK_LINEAR_WINDOW_CTRL 8'h9b
`define MASK_LINEAR_BASE        8'hff
`define MASK_GENERAL_OUTPUT     8'hff
`define MASK_HORIZ_OVERFLOW     8'h7f
`define MASK_VERT_OVERFLOW      8'h57

// reset values
`define RST_EXT_REG    8'h00
`define RST_LOCK_KEY   8'h00
`define RST_INDEX      8'h00

// unlock key pattern; value arbitrary
`define UNLOCK_KEY     8'h5a

// mapped io window bases
`define MAPPED_IO_BASE_LOW  20'ha8000
`define MAPPED_IO_BASE_HIGH 20'hb8000

// field positions
`define F_SCREEN_MSB      0
`define F_PIXEL_LEN_LO    4
`define F_PIXEL_LEN_HI    5
`define F_SCREEN_LO       6
`define F_SCREEN_HI       7
`define F_NIBBLE_SWAP     6
`define F_MAPPED_IO_SEL   5
`define F_GIP_EN          2
`define F_X11_CURSOR      4
`define F_VIDEO_CLK_FLOAT 7
`define F_HSYNC_FLOAT     1
`define F_VSYNC_FLOAT     2
`define F_LATCH_TIMING    3
`define F_LINEAR_EN       4
`define F_RAS_ADJ         7

`endif

// ==== masked_reg.v ====
// one byte register whose reserved bits stay zero
`timescale 1ns/100ps
module masked_reg #(
  parameter [7:0] MASK  = 8'hff,
  parameter [7:0] RESET = 8'h00
) (
  input  wire       clk_i,
  input  wire       srst_i,
  input  wire       we_i,
  input  wire [7:0] d_i,
  output reg  [7:0] q_o
);

  always @(posedge clk_i) begin
    if (srst_i) begin
      q_o <= RESET & MASK;
    end else if (we_i) begin
      q_o <= d_i & MASK;
    end
  end

endmodule // masked_reg

// ==== index_lock.v ====
// crt index register and lock key register with unlock detection
`timescale 1ns/100ps
`include "system_extension_regs_map.vh"
module index_lock #(
  parameter [7:0] KEY = `UNLOCK_KEY
) (
  input  wire       clk_i,
  input  wire       srst_i,
  input  wire       idx_wr_i,
  input  wire       data_wr_i,
  input  wire [7:0] wdata_i,
  output reg  [7:0] index_o,
  output reg  [7:0] lock_key_o,
  output reg        unlocked_o
);

  // index register; a data access in the same cycle uses the old index
  always @(posedge clk_i) begin
    if (srst_i) begin
      index_o <= `RST_INDEX;
    end else if (idx_wr_i) begin
      index_o <= wdata_i;
    end
  end

  // locked at reset, open while key held
  always @(posedge clk_i) begin
    if (srst_i) begin
      lock_key_o <= `RST_LOCK_KEY;
      unlocked_o <= 1'b0;
    end else if (data_wr_i && index_o == `IDX_LOCK_KEY_TWO) begin
      lock_key_o <= wdata_i;
      unlocked_o <= (wdata_i == KEY);
    end
  end

endmodule // index_lock

// ==== system_extension_regs.v ====
// system extension register bank behind the indexed crt register port
`timescale 1ns/100ps
`include "system_extension_regs_map.vh"
module system_extension_regs #(
  parameter [7:0] KEY = `UNLOCK_KEY
) (
  input  wire        clk_i,
  input  wire        srst_i,
  // indexed register port
  input  wire        idx_wr_i,
  input  wire        data_wr_i,
  input  wire        data_rd_i,
  input  wire [7:0]  wdata_i,
  output reg  [7:0]  rdata_o,
  output reg         rvalid_o,
  // general input port
  input  wire [7:0]  gen_in_i,
  input  wire        gip_rd_i,
  output reg  [7:0]  gip_data_o,
  output reg         gip_valid_o,
  // decoded controls
  output wire        unlocked_o,
  output wire [2:0]  screen_width_o,
  output wire [1:0]  pixel_length_o,
  output wire [1:0]  logical_width_hi_o,
  output wire [1:0]  old_display_start_hi_o,
  output wire [1:0]  old_host_base_hi_o,
  output wire [7:0]  firmware_flag_o,
  output wire [1:0]  linear_swap_mode_o,
  output wire [1:0]  mapped_io_window_type_o,
  output reg  [19:0] mapped_io_window_base_o,
  output wire        nibble_swap_o,
  output wire [1:0]  other_swap_mode_o,
  output wire [5:0]  fifo_m_param_o,
  output wire        x11_cursor_o,
  output wire        video_clock_out_oe_n_o,
  output wire        hsync_oe_n_o,
  output wire        vsync_oe_n_o,
  output wire [1:0]  linear_window_size_o,
  output wire        linear_enable_o,
  output wire        ras_timing_adj_o,
  output wire        latch_timing_o,
  output wire [15:0] linear_window_base_o,
  output wire [7:0]  general_out_o,
  output wire        htotal_b8_o,
  output wire        hdisp_end_b8_o,
  output wire        hblank_start_b8_o,
  output wire        hblank_end_b7_o,
  output wire        hsync_start_b8_o,
  output wire        hsync_end_b6_o,
  output wire        fifo_fetch_b8_o,
  output wire        vtotal_b10_o,
  output wire        vdisp_end_b10_o,
  output wire        vblank_start_b10_o,
  output wire        vretrace_start_b10_o,
  output wire        line_compare_b10_o
);

  // ****************************************************************
  // register table
  // ****************************************************************
  // the table is walked by constant functions so the generate loop below
  // can give each entry its own index and reserved-bit mask at elaboration
  localparam NREG = 13;

  // index of each table entry
  function [7:0] reg_index;
    input integer n;
    begin
      case (n)
        0:       reg_index = `IDX_EXT_SYSTEM_CTRL_A;
        1:       reg_index = `IDX_EXT_SYSTEM_CTRL_B;
        2:       reg_index = `IDX_FIRMWARE_FLAG_A;
        3:       reg_index = `IDX_MEMORY_CTRL_A;
        4:       reg_index = `IDX_MEMORY_CTRL_B;
        5:       reg_index = `IDX_PALETTE_EXT_CTRL;
        6:       reg_index = `IDX_EXTERNAL_SYNC_CTRL;
        7:       reg_index = `IDX_LINEAR_WINDOW_CTRL;
        8:       reg_index = `IDX_LINEAR_BASE_HI;
        9:       reg_index = `IDX_LINEAR_BASE_LO;
        10:      reg_index = `IDX_GENERAL_OUTPUT;
        11:      reg_index = `IDX_HORIZ_OVERFLOW;
        default: reg_index = `IDX_VERT_OVERFLOW;
      endcase
    end
  endfunction

  // writable mask of each table entry
  function [7:0] reg_mask;
    input integer n;
    begin
      case (n)
        0:       reg_mask = `MASK_EXT_SYSTEM_CTRL_A;
        1:       reg_mask = `MASK_EXT_SYSTEM_CTRL_B;
        2:       reg_mask = `MASK_FIRMWARE_FLAG_A;
        3:       reg_mask = `MASK_MEMORY_CTRL_A;
        4:       reg_mask = `MASK_MEMORY_CTRL_B;
        5:       reg_mask = `MASK_PALETTE_EXT_CTRL;
        6:       reg_mask = `MASK_EXTERNAL_SYNC_CTRL;
        7:       reg_mask = `MASK_LINEAR_WINDOW_CTRL;
        8:       reg_mask = `MASK_LINEAR_BASE;
        9:       reg_mask = `MASK_LINEAR_BASE;
        10:      reg_mask = `MASK_GENERAL_OUTPUT;
        11:      reg_mask = `MASK_HORIZ_OVERFLOW;
        default: reg_mask = `MASK_VERT_OVERFLOW;
      endcase
    end
  endfunction

  // ****************************************************************
  // index and lock
  // ****************************************************************
  wire [7:0] index;
  wire [7:0] lock_key;
  wire       unlocked;

  // the lock state is kept in one place; the register write strobes below are qualified by it
  // a data access in the same cycle as an index write still uses the old index
  index_lock #(
    .KEY (KEY)
  ) u_index_lock (
    .clk_i      (clk_i),
    .srst_i     (srst_i),
    .idx_wr_i   (idx_wr_i),
    .data_wr_i  (data_wr_i),
    .wdata_i    (wdata_i),
    .index_o    (index),
    .lock_key_o (lock_key),
    .unlocked_o (unlocked)
  );

  // ****************************************************************
  // register storage
  // ****************************************************************
  // one masked byte per table entry; the window base pair is two independent
  // bytes, the lower index holding the upper half
  wire [7:0] q [0:NREG-1];

  genvar g;
  generate
    // a write to an unmapped index matches no entry and is dropped
    for (g = 0; g < NREG; g = g + 1) begin : g_reg
      wire we = data_wr_i && unlocked && (index == reg_index(g));
      masked_reg #(
        .MASK  (reg_mask(g)),
        .RESET (`RST_EXT_REG)
      ) u_reg (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .we_i   (we),
        .d_i    (wdata_i),
        .q_o    (q[g])
      );
    end
  endgenerate

  // ****************************************************************
  // read path
  // ****************************************************************
  reg [7:0] next_rdata;

  // the lock register itself stays readable, so software can tell whether
  // the bank is open before it touches any extension register
  // locked reads return zero; unmapped indices read zero too
  always @* begin
    next_rdata = 8'h00;
    if (index == `IDX_LOCK_KEY_TWO) begin
      next_rdata = lock_key;
    end else if (!unlocked) begin
      next_rdata = 8'h00;
    end else if (index == `IDX_EXT_SYSTEM_CTRL_A) begin
      next_rdata = q[0];
    end else if (index == `IDX_EXT_SYSTEM_CTRL_B) begin
      next_rdata = q[1];
    end else if (index == `IDX_FIRMWARE_FLAG_A) begin
      next_rdata = q[2];
    end else if (index == `IDX_MEMORY_CTRL_A) begin
      next_rdata = q[3];
    end else if (index == `IDX_MEMORY_CTRL_B) begin
      next_rdata = q[4];
    end else if (index == `IDX_PALETTE_EXT_CTRL) begin
      next_rdata = q[5];
    end else if (index == `IDX_EXTERNAL_SYNC_CTRL) begin
      next_rdata = q[6];
    end else if (index == `IDX_LINEAR_WINDOW_CTRL) begin
      next_rdata = q[7];
    end else if (index == `IDX_LINEAR_BASE_HI) begin
      next_rdata = q[8];
    end else if (index == `IDX_LINEAR_BASE_LO) begin
      next_rdata = q[9];
    end else if (index == `IDX_GENERAL_OUTPUT) begin
      next_rdata = q[10];
    end else if (index == `IDX_HORIZ_OVERFLOW) begin
      next_rdata = q[11];
    end else if (index == `IDX_VERT_OVERFLOW) begin
      next_rdata = q[12];
    end
  end

  // read data registered one cycle after the strobe
  // capturing only on a strobe keeps rdata_o steady until the next read
  always @(posedge clk_i) begin
    if (srst_i) begin
      rdata_o  <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= data_rd_i;
      if (data_rd_i) begin
        rdata_o <= next_rdata;
      end
    end
  end

  // ****************************************************************
  // general input port
  // ****************************************************************
  // the pins are taken as they stand; they must already be synchronous to clk_i

  always @(posedge clk_i) begin
    if (srst_i) begin
      gip_data_o  <= 8'h00;
      gip_valid_o <= 1'b0;
    end else begin
      gip_valid_o <= gip_rd_i;
      if (gip_rd_i) begin
        gip_data_o <= q[5][`F_GIP_EN] ? gen_in_i : 8'h00;
      end
    end
  end

  // ****************************************************************
  // mapped io window
  // ****************************************************************
  // the extra flop keeps this output registered; it trails the select bit by one cycle

  // window base registered from select bit
  always @(posedge clk_i) begin
    if (srst_i) begin
      mapped_io_window_base_o <= `MAPPED_IO_BASE_LOW;
    end else begin
      mapped_io_window_base_o <= q[3][`F_MAPPED_IO_SEL] ? `MAPPED_IO_BASE_HIGH : `MAPPED_IO_BASE_LOW;
    end
  end

  // ****************************************************************
  // field decode; every output is a slice of a register
  // ****************************************************************
  // each output is a register bit, so it changes the cycle after its write
  // the lock flag is already a flop inside index_lock
  assign unlocked_o = unlocked;

  // ****************************************************************
  // system and memory control fields
  // ****************************************************************

  assign screen_width_o = {q[0][`F_SCREEN_MSB], q[0][`F_SCREEN_HI:`F_SCREEN_LO]};
  assign pixel_length_o = q[0][`F_PIXEL_LEN_HI:`F_PIXEL_LEN_LO];

  assign logical_width_hi_o = q[1][5:4];

  assign old_display_start_hi_o = q[1][1:0];
  assign old_host_base_hi_o     = q[1][3:2];

  // firmware scratch byte; the hardware gives it no meaning
  assign firmware_flag_o = q[2];

  assign linear_swap_mode_o = q[3][2:1];

  assign mapped_io_window_type_o = q[3][4:3];

  assign nibble_swap_o = q[3][`F_NIBBLE_SWAP];

  assign other_swap_mode_o = q[4][1:0];

  // bit 2 is the lowest bit of the parameter, bits 7-3 sit above it
  // m parameter, bit 2 lowest
  assign fifo_m_param_o = {q[4][7:3], q[4][2]};

  // ****************************************************************
  // palette, sync and window controls
  // ****************************************************************

  assign x11_cursor_o = q[5][`F_X11_CURSOR];

  // the pad cells sit outside this block; only their enables are made here
  // video clock float; enable low drives the pin
  assign video_clock_out_oe_n_o = q[5][`F_VIDEO_CLK_FLOAT];

  assign hsync_oe_n_o = q[6][`F_HSYNC_FLOAT];

  assign vsync_oe_n_o = q[6][`F_VSYNC_FLOAT];

  // reserved bits 2, 5 and 6 never reach an output
  // linear window size and enable
  assign linear_window_size_o = q[7][1:0];
  assign linear_enable_o      = q[7][`F_LINEAR_EN];
  assign ras_timing_adj_o     = q[7][`F_RAS_ADJ];

  assign latch_timing_o = q[7][`F_LATCH_TIMING];

  // the upper byte of the pair lands on host address bits 31-24
  // window base, host bits 31-16
  assign linear_window_base_o = {q[8], q[9]};

  assign general_out_o = q[10];

  // ****************************************************************
  // crt timing overflow
  // ****************************************************************
  // these bits only widen timing values held elsewhere in the crt block

  assign htotal_b8_o       = q[11][0];
  assign hdisp_end_b8_o    = q[11][1];
  assign hblank_start_b8_o = q[11][2];
  assign hblank_end_b7_o   = q[11][3];
  assign hsync_start_b8_o  = q[11][4];
  assign hsync_end_b6_o    = q[11][5];
  assign fifo_fetch_b8_o   = q[11][6];

  assign vtotal_b10_o         = q[12][0];
  assign vdisp_end_b10_o      = q[12][1];
  assign vblank_start_b10_o   = q[12][2];
  assign vretrace_start_b10_o = q[12][4];
  assign line_compare_b10_o   = q[12][6];

endmodule // system_extension_regs

// ==== system_extension_regs_checker.sv ====
// port-level assertions for the system extension register bank
`timescale 1ns/100ps
module system_extension_regs_checker #(
  parameter [7:0] KEY = 8'h5a
) (
  input wire        clk_i,
  input wire        srst_i,
  input wire        idx_wr_i,
  input wire        data_wr_i,
  input wire        data_rd_i,
  input wire [7:0]  wdata_i,
  input wire [7:0]  rdata_o,
  input wire        rvalid_o,
  input wire        unlocked_o,
  input wire [2:0]  screen_width_o,
  input wire [1:0]  pixel_length_o,
  input wire [1:0]  old_host_base_hi_o,
  input wire [1:0]  linear_swap_mode_o,
  input wire [19:0] mapped_io_window_base_o,
  input wire        video_clock_out_oe_n_o,
  input wire        x11_cursor_o,
  input wire        hsync_oe_n_o,
  input wire        vsync_oe_n_o,
  input wire [7:0]  general_out_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // shadow of the index, so checks know where a data access lands
  reg  [7:0] idx;
  wire       unl_wr = data_wr_i && unlocked_o;
  always @(posedge clk_i) begin
    if (srst_i) idx <= 8'h00;
    else if (idx_wr_i) idx <= wdata_i;
  end
  a_read_valid_pulse: assert property (data_rd_i |=> rvalid_o) else $error("read not answered");
  a_locked_read_zero: assert property (data_rd_i && !unlocked_o && idx[7:4] == 4'h5 |=> rdata_o == 8'h00)
    else $error("locked read not zero");
  a_locked_write_ignored: assert property (data_wr_i && !unlocked_o && idx == 8'h5c |=> $stable(general_out_o))
    else $error("locked write took effect");
  a_unlock_key_match: assert property (data_wr_i && idx == 8'h39 |=> unlocked_o == ($past(wdata_i) == KEY))
    else $error("unlock state wrong");
  a_screen_width_bits: assert property (unl_wr && idx == 8'h50 |=>
    screen_width_o == {$past(wdata_i[0]), $past(wdata_i[7:6])} && pixel_length_o == $past(wdata_i[5:4]))
    else $error("screen width field wrong");
  a_host_base_hi: assert property (unl_wr && idx == 8'h51 |=> old_host_base_hi_o == $past(wdata_i[3:2]))
    else $error("host base bits wrong");
  a_linear_swap_mode: assert property (unl_wr && idx == 8'h53 |=> linear_swap_mode_o == $past(wdata_i[2:1]))
    else $error("linear swap mode wrong");
  a_window_base_sel: assert property (unl_wr && idx == 8'h53 |=> ##1
    mapped_io_window_base_o == ($past(wdata_i[5], 2) ? 20'hb8000 : 20'ha8000)) else $error("window base wrong");
  a_palette_pin_ctrl: assert property (unl_wr && idx == 8'h55 |=>
    x11_cursor_o == $past(wdata_i[4]) && video_clock_out_oe_n_o == $past(wdata_i[7])) else $error("palette ctrl wrong");
  a_sync_float_ctrl: assert property (unl_wr && idx == 8'h56 |=>
    hsync_oe_n_o == $past(wdata_i[1]) && vsync_oe_n_o == $past(wdata_i[2])) else $error("sync float wrong");
  a_gen_out_value: assert property (unl_wr && idx == 8'h5c |=> general_out_o == $past(wdata_i))
    else $error("general output wrong");
  a_reserved_zero: assert property (data_rd_i && idx == 8'h56 |=> (rdata_o & 8'hf9) == 8'h00)
    else $error("reserved bits not zero");
endmodule // system_extension_regs_checker
bind system_extension_regs system_extension_regs_checker #(.KEY(KEY)) system_extension_regs_checker_inst (
  .clk_i, .srst_i, .idx_wr_i, .data_wr_i, .data_rd_i, .wdata_i, .rdata_o, .rvalid_o, .unlocked_o,
  .screen_width_o, .pixel_length_o, .old_host_base_hi_o, .linear_swap_mode_o, .mapped_io_window_base_o,
  .video_clock_out_oe_n_o, .x11_cursor_o, .hsync_oe_n_o, .vsync_oe_n_o, .general_out_o);

// ==== system_extension_regs_tb.sv ====
// self-checking bench for the system extension register bank
`timescale 1ns/100ps
module system_extension_regs_tb;
  localparam [7:0] KEY = 8'h5a;
  reg         clk_i, srst_i, idx_wr_i, data_wr_i, data_rd_i, gip_rd_i;
  reg  [7:0]  wdata_i, gen_in_i;
  wire [7:0]  rdata_o, gip_data_o, firmware_flag_o, general_out_o;
  wire        rvalid_o, gip_valid_o, unlocked_o, nibble_swap_o, x11_cursor_o, latch_timing_o;
  wire        video_clock_out_oe_n_o, hsync_oe_n_o, vsync_oe_n_o, linear_enable_o, ras_timing_adj_o;
  wire        htotal_b8_o, hdisp_end_b8_o, hblank_start_b8_o, hblank_end_b7_o, hsync_start_b8_o;
  wire        hsync_end_b6_o, fifo_fetch_b8_o, vtotal_b10_o, vdisp_end_b10_o, vblank_start_b10_o;
  wire        vretrace_start_b10_o, line_compare_b10_o;
  wire [1:0]  pixel_length_o, logical_width_hi_o, old_display_start_hi_o, old_host_base_hi_o;
  wire [1:0]  linear_swap_mode_o, mapped_io_window_type_o, other_swap_mode_o, linear_window_size_o;
  wire [2:0]  screen_width_o;
  wire [5:0]  fifo_m_param_o;
  wire [15:0] linear_window_base_o;
  wire [19:0] mapped_io_window_base_o;
  integer     err_count = 0;
  integer     checks = 0;
  // index and writable mask; 57 and 5b are unmapped
  logic [15:0] tbl [0:14] = '{16'h50f1, 16'h513f, 16'h52ff, 16'h537e, 16'h54ff, 16'h5594, 16'h5606,
                              16'h57_00, 16'h589b, 16'h59ff, 16'h5aff, 16'h5b00, 16'h5cff, 16'h5d7f, 16'h5e57};
  system_extension_regs #(.KEY(KEY)) system_extension_regs_inst (.*);
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // ****************************************
  // access tasks
  // ****************************************
  task chk(input [19:0] s, input [19:0] e);
    checks = checks + 1;
    if (s !== e) begin
      err_count = err_count + 1;
      $display("FAIL at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // inputs always move 1 ns after the edge
  task step;
    @(posedge clk_i);
    #1;
  endtask
  task wr(input [7:0] i, input [7:0] d);
    idx_wr_i = 1'b1;
    wdata_i = i;
    step;
    idx_wr_i = 1'b0;
    data_wr_i = 1'b1;
    wdata_i = d;
    step;
    data_wr_i = 1'b0;
  endtask
  task rd(input [7:0] i, input [7:0] e);
    idx_wr_i = 1'b1;
    wdata_i = i;
    step;
    idx_wr_i = 1'b0;
    data_rd_i = 1'b1;
    step;
    data_rd_i = 1'b0;
    chk(rvalid_o, 1);
    chk(rdata_o, e);
  endtask
  task gipr(input [7:0] e);
    gip_rd_i = 1'b1;
    step;
    gip_rd_i = 1'b0;
    chk(gip_valid_o, 1);
    chk(gip_data_o, e);
  endtask
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ****************************************
  // tests
  // ****************************************
  // the whole run is under two hundred cycles
  initial begin
    #100000;
    err_count = err_count + 1;
    report_and_stop;
  end
  initial begin
    srst_i = 1'b1;
    {idx_wr_i, data_wr_i, data_rd_i, gip_rd_i} = 4'h0;
    wdata_i = 8'h00;
    gen_in_i = 8'h3c;
    repeat (10) step;
    srst_i = 1'b0;
    chk(unlocked_o, 0);
    chk(mapped_io_window_base_o, 20'ha8000);
    wr(8'h5c, 8'haa);
    chk(general_out_o, 0);
    rd(8'h5c, 8'h00);
    wr(8'h39, KEY);
    chk(unlocked_o, 1);
    rd(8'h39, KEY);
    $display("test lock done");
    for (int n = 0; n < 15; n++) begin
      wr(tbl[n][15:8], 8'hff);
      rd(tbl[n][15:8], tbl[n][7:0]);
      wr(tbl[n][15:8], 8'h00);
      rd(tbl[n][15:8], 8'h00);
    end
    $display("test masks done");
    wr(8'h50, 8'hb1);
    chk({screen_width_o, pixel_length_o}, 5'b11011);
    wr(8'h51, 8'h1b);
    chk({logical_width_hi_o, old_host_base_hi_o, old_display_start_hi_o}, 6'b011011);
    wr(8'h53, 8'h6a);
    chk({nibble_swap_o, mapped_io_window_type_o, linear_swap_mode_o}, 5'b10101);
    step;
    chk(mapped_io_window_base_o, 20'hb8000);
    wr(8'h54, 8'hae);
    chk({fifo_m_param_o, other_swap_mode_o}, 8'hae);
    wr(8'h55, 8'h80);
    chk({x11_cursor_o, video_clock_out_oe_n_o}, 2'b01);
    gipr(8'h00);
    wr(8'h55, 8'h14);
    gipr(8'h3c);
    chk({x11_cursor_o, video_clock_out_oe_n_o}, 2'b10);
    wr(8'h56, 8'h02);
    chk({hsync_oe_n_o, vsync_oe_n_o}, 2'b10);
    wr(8'h56, 8'h04);
    chk({hsync_oe_n_o, vsync_oe_n_o}, 2'b01);
    wr(8'h58, 8'h9a);
    chk({ras_timing_adj_o, linear_enable_o, latch_timing_o, linear_window_size_o}, 5'b11110);
    wr(8'h59, 8'h12);
    wr(8'h5a, 8'h34);
    chk(linear_window_base_o, 16'h1234);
    wr(8'h52, 8'h5a);
    chk(firmware_flag_o, 8'h5a);
    wr(8'h5c, 8'hc3);
    chk(general_out_o, 8'hc3);
    wr(8'h5d, 8'h55);
    chk({fifo_fetch_b8_o, hsync_end_b6_o, hsync_start_b8_o, hblank_end_b7_o, hblank_start_b8_o,
         hdisp_end_b8_o, htotal_b8_o}, 7'h55);
    wr(8'h5e, 8'h45);
    chk({line_compare_b10_o, vretrace_start_b10_o, vblank_start_b10_o, vdisp_end_b10_o,
         vtotal_b10_o}, 5'h15);
    $display("test fields done");
    wr(8'h39, 8'h00);
    chk(unlocked_o, 0);
    wr(8'h5c, 8'h11);
    chk(general_out_o, 8'hc3);
    rd(8'h5c, 8'h00);
    rd(8'h39, 8'h00);
    $display("test relock done");
    wr(8'h39, KEY);
    srst_i = 1'b1;
    repeat (2) step;
    srst_i = 1'b0;
    chk(unlocked_o, 0);
    chk(general_out_o, 8'h00);
    rd(8'h5c, 8'h00);
    $display("test reset relock done");
    report_and_stop;
  end
endmodule // system_extension_regs_tb
